// ==== rtl/tmr_pkg.sv ====
// Constants for the timer block: register map, reset values, timing
`default_nettype none
package tmr_pkg;
    // Register indexes; the byte address is four times the index
    localparam logic [5:0] IDX_FREE_LO   = 6'h20;
    localparam logic [5:0] IDX_FREE_HI   = 6'h21;
    localparam logic [5:0] IDX_IVL_CNT_LO = 6'h26;
    localparam logic [5:0] IDX_IVL_CNT_HI = 6'h27;
    localparam logic [5:0] IDX_IVL_RLD_LO = 6'h28;
    localparam logic [5:0] IDX_IVL_RLD_HI = 6'h29;
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    // Field layout
    localparam int         FREE_W        = 16;
    localparam int         IVL_W         = 12;
    localparam int         BYTE_W        = 8;
    localparam int         NIB_W         = 4;
    // Reset values
    localparam logic [15:0] FREE_RST     = 16'h0000;
    localparam logic [11:0] IVL_RST      = 12'h000;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    // Timing
    localparam int         CLK_MHZ       = 125;
    localparam int         TB_MHZ        = 4;
    localparam int         TICK_US       = 1024;
    localparam int         TICK_COUNTS   = TICK_US * TB_MHZ;
    localparam int         OVF_US        = 16384;
endpackage : tmr_pkg
`default_nettype wire

// ==== rtl/tmr_tb_if.sv ====
// Timebase enable carried from the divider to the timer core
`default_nettype none
interface tmr_tb_if;
    logic tb_en;
    modport src (output tb_en);
    modport snk (input tb_en);
endinterface : tmr_tb_if
`default_nettype wire

// ==== rtl/tmr_timebase.sv ====
// Fractional divider making the timer timebase enable from pclk
`default_nettype none
module tmr_timebase #(
    parameter int CLK_MHZ = tmr_pkg::CLK_MHZ,
    parameter int TB_MHZ  = tmr_pkg::TB_MHZ
) (
    input  wire logic pclk,
    input  wire logic presetn,
    tmr_tb_if.src     tb
);
    localparam int ACC_W = $clog2(CLK_MHZ + TB_MHZ + 1);
    localparam logic [ACC_W-1:0] STEP = ACC_W'(TB_MHZ);
    localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_MHZ);

    initial begin
        if (TB_MHZ < 1 || TB_MHZ >= CLK_MHZ)
            $error("timebase rate must lie below the bus clock rate");
    end

    logic [ACC_W-1:0] acc_q;
    logic             en_q;
    wire  [ACC_W-1:0] acc_sum = acc_q + STEP;
    wire              acc_ovf = acc_sum >= WRAP;
    wire  [ACC_W-1:0] acc_d   = acc_ovf ? acc_sum - WRAP : acc_sum;

    // Average rate is exactly TB_MHZ; single pulses, jitter one pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
            en_q  <= 1'b0;
        end else begin
            acc_q <= acc_d;
            en_q  <= acc_ovf;
        end
    end

    assign tb.tb_en = en_q;
endmodule : tmr_timebase
`default_nettype wire

// ==== rtl/tmr_block.sv ====
// Timer block: free-running counter, interval timer, APB registers
//
// Summary of operation
// - A 16-bit counter counts up freely on a 4 MHz timebase, not on the processor clock.
// - The timer logic runs apart from processor accesses, which reach it without tearing a count.
// - The free count is the capture time base and software can read it.
// - Reading the low count byte copies the upper byte into a hold that the upper read returns.
// - A read samples all 16 bits at the low read; a write loads both bytes at the upper write.
// - A tick interrupt is raised from its own timebase counter, not the free count, every 1024 microseconds.
// - A wrap interrupt is raised each time the 16-bit count overflows, every 16.384 ms.
// - The 12-bit interval count reads through two registers, the upper nibble held at the low read.
// - The 12-bit reload sits in a low byte and in bits 3:0 of the upper register.
// - The wrap event leaves the block as its own interrupt source.
`default_nettype none
module tmr_block #(
    parameter int TB_MHZ  = tmr_pkg::TB_MHZ,
    parameter int TICK_US = tmr_pkg::TICK_US
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tmr_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [tmr_pkg::DATA_W-1:0]  pwdata,
    output logic      [tmr_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic      [tmr_pkg::FREE_W-1:0]  capture_time,
    output logic                             tick_irq,
    output logic                             wrap_irq,
    output logic                             interval_irq
);
    localparam int FW = tmr_pkg::FREE_W;
    localparam int IW = tmr_pkg::IVL_W;
    localparam int BW = tmr_pkg::BYTE_W;
    localparam int NW = tmr_pkg::NIB_W;
    localparam int TICK_N = TICK_US * TB_MHZ;
    localparam int TK_W = $clog2(TICK_N);
    localparam logic [TK_W-1:0] TICK_LAST = TK_W'(TICK_N - 1);

    initial begin
        if (TICK_N < 2)
            $error("tick period must span at least two timebase counts");
    end

    // Register decode, used for both the setup and the access phase
    function automatic logic hit(input logic [tmr_pkg::ADDR_W-1:0] a,
                                 input logic [5:0] idx);
        return (a[1:0] == 2'h0) && (a[tmr_pkg::ADDR_W-1:2] == idx);
    endfunction

    tmr_tb_if tbi ();

    tmr_timebase #(
        .CLK_MHZ (tmr_pkg::CLK_MHZ),
        .TB_MHZ  (TB_MHZ)
    ) u_timebase (
        .pclk    (pclk),
        .presetn (presetn),
        .tb      (tbi)
    );

    wire tb_en = tbi.tb_en;

    // Bus phases
    wire setup_ph  = psel && !penable;
    wire access_ph = psel && penable;

    wire sel_free_lo = hit(paddr, tmr_pkg::IDX_FREE_LO);
    wire sel_free_hi = hit(paddr, tmr_pkg::IDX_FREE_HI);
    wire sel_ivc_lo  = hit(paddr, tmr_pkg::IDX_IVL_CNT_LO);
    wire sel_ivc_hi  = hit(paddr, tmr_pkg::IDX_IVL_CNT_HI);
    wire sel_rld_lo  = hit(paddr, tmr_pkg::IDX_IVL_RLD_LO);
    wire sel_rld_hi  = hit(paddr, tmr_pkg::IDX_IVL_RLD_HI);
    wire mapped      = sel_free_lo | sel_free_hi | sel_ivc_lo |
                       sel_ivc_hi  | sel_rld_lo  | sel_rld_hi;

    wire wr_done  = access_ph && pwrite && mapped;
    wire rd_setup = setup_ph && !pwrite;

    wire wr_free_lo = wr_done && sel_free_lo;
    wire wr_free_hi = wr_done && sel_free_hi;
    wire wr_rld_lo  = wr_done && sel_rld_lo;
    wire wr_rld_hi  = wr_done && sel_rld_hi;
    wire rd_free_lo = rd_setup && sel_free_lo;
    wire rd_ivc_lo  = rd_setup && sel_ivc_lo;

    // Storage
    logic [FW-1:0]   free_q;
    logic [BW-1:0]   free_stage_q;
    logic [BW-1:0]   free_hold_q;
    logic [IW-1:0]   ivl_q;
    logic [NW-1:0]   ivl_hold_q;
    logic [IW-1:0]   reload_q;
    logic [TK_W-1:0] tick_q;
    logic [tmr_pkg::DATA_W-1:0] rdata_q;
    logic            tick_irq_q;
    logic            wrap_irq_q;
    logic            ivl_irq_q;

    // counter load at upper write, wins over counting
    wire [FW-1:0] free_load = {pwdata[BW-1:0], free_stage_q};
    // A load in the same cycle replaces the wrap, so no false event
    wire          free_wrap = tb_en && !wr_free_hi &&
                              (free_q == {FW{1'b1}});
    wire [FW-1:0] free_d    = wr_free_hi ? free_load :
                              tb_en      ? free_q + 1'b1 : free_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            free_q <= tmr_pkg::FREE_RST;
        end else begin
            free_q <= free_d;
        end
    end

    // low byte staged until the upper write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            free_stage_q <= tmr_pkg::BYTE_RST;
        end else if (wr_free_lo) begin
            free_stage_q <= pwdata[BW-1:0];
        end
    end

    // upper byte held at low read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            free_hold_q <= tmr_pkg::BYTE_RST;
        end else if (rd_free_lo) begin
            free_hold_q <= free_q[FW-1:BW];
        end
    end

    wire tick_end = tb_en && (tick_q == TICK_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= '0;
        end else if (tick_end) begin
            tick_q <= '0;
        end else if (tb_en) begin
            tick_q <= tick_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_q <= tmr_pkg::IVL_RST;
        end else if (wr_rld_lo) begin
            reload_q[BW-1:0] <= pwdata[BW-1:0];
        end else if (wr_rld_hi) begin
            reload_q[IW-1:BW] <= pwdata[NW-1:0];
        end
    end

    // count down, reload at terminal count
    wire          ivl_term = tb_en && (ivl_q == '0);
    wire [IW-1:0] ivl_d    = !tb_en   ? ivl_q :
                             ivl_term ? reload_q : ivl_q - 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ivl_q <= tmr_pkg::IVL_RST;
        end else begin
            ivl_q <= ivl_d;
        end
    end

    // upper nibble held at low read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ivl_hold_q <= '0;
        end else if (rd_ivc_lo) begin
            ivl_hold_q <= ivl_q[IW-1:BW];
        end
    end

    // read data taken in one pclk edge, so no byte tears
    wire [BW-1:0] rd_byte =
        sel_free_lo ? free_q[BW-1:0] :
        sel_free_hi ? free_hold_q :
        sel_ivc_lo  ? ivl_q[BW-1:0] :
        sel_ivc_hi  ? {{(BW-NW){1'b0}}, ivl_hold_q} :
        sel_rld_lo  ? reload_q[BW-1:0] :
        sel_rld_hi  ? {{(BW-NW){1'b0}}, reload_q[IW-1:BW]} : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else if (rd_setup) begin
            rdata_q <= {{(tmr_pkg::DATA_W-BW){1'b0}}, rd_byte};
        end
    end

    // event pulses to the interrupt controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_irq_q <= 1'b0;
            wrap_irq_q <= 1'b0;
            ivl_irq_q  <= 1'b0;
        end else begin
            tick_irq_q <= tick_end;
            wrap_irq_q <= free_wrap;
            ivl_irq_q  <= ivl_term;
        end
    end

    assign prdata       = rdata_q;
    assign pready       = 1'b1;
    assign pslverr      = access_ph && !mapped;
    assign capture_time = free_q;
    assign tick_irq     = tick_irq_q;
    assign wrap_irq     = wrap_irq_q;
    assign interval_irq = ivl_irq_q;
endmodule : tmr_block
`default_nettype wire

// ==== tb/tmr_block_checker.sv ====
// Port assertions for the timer block
`default_nettype none
module tmr_block_checker #(
    parameter int TB_MHZ  = 4,
    parameter int TICK_US = 1024
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] capture_time,
    input wire logic        tick_irq,
    input wire logic        wrap_irq,
    input wire logic        interval_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic       acc = psel && penable;
    wire logic       setup = psel && !penable && !pwrite;
    wire logic       lo_rd = setup && paddr == 8'h80;
    wire logic       hi_wr = acc && pwrite && paddr == 8'h84;
    logic      [7:0] hold_q;
    // Upper byte seen at the last low read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hold_q <= 8'h00;
        else if (lo_rd) hold_q <= capture_time[15:8];
    end
    sequence s_lo_rd; lo_rd; endsequence
    sequence s_hi_rd; setup && paddr == 8'h84; endsequence
    property p_ready; pready; endproperty
    property p_rd_lo;
        s_lo_rd |=> prdata[7:0] == $past(capture_time[7:0]);
    endproperty
    property p_hold; s_hi_rd |=> prdata[7:0] == hold_q; endproperty
    property p_ld; hi_wr |=> capture_time[15:8] == $past(pwdata[7:0]);
    endproperty
    property p_inc; $changed(capture_time) && !$past(hi_wr) |->
        capture_time == $past(capture_time) + 16'h0001; endproperty
    property p_tick; tick_irq |=> !tick_irq [*8]; endproperty
    property p_wrap; wrap_irq |-> capture_time == 16'h0000 ##1 !wrap_irq;
    endproperty
    property p_ivl; interval_irq |=> !interval_irq [*8]; endproperty
    property p_ro; acc && (paddr == 8'h98 || paddr == 8'h9C) |-> !pslverr;
    endproperty
    property p_rsv; setup && paddr == 8'hA4 |=> prdata[7:4] == 4'h0;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state");
    a_rd_lo: assert property (p_rd_lo) else $error("low read");
    a_hold: assert property (p_hold) else $error("held byte");
    a_ld: assert property (p_ld) else $error("count load");
    a_inc: assert property (p_inc) else $error("count step");
    a_tick: assert property (p_tick) else $error("tick pulse");
    a_wrap: assert property (p_wrap) else $error("wrap pulse");
    a_ivl: assert property (p_ivl) else $error("interval pulse");
    a_ro: assert property (p_ro) else $error("count write error");
    a_rsv: assert property (p_rsv) else $error("reserved bits");
endmodule // tmr_block_checker
bind tmr_block tmr_block_checker #(.TB_MHZ(TB_MHZ), .TICK_US(TICK_US))
    u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_time(capture_time), .tick_irq(tick_irq),
    .wrap_irq(wrap_irq), .interval_irq(interval_irq));
`default_nettype wire

// ==== tb/tmr_block_test.sv ====
// Self-checking bench for the timer block
`default_nettype none
module tmr_block_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [15:0] capture_time;
    logic        pready, pslverr, tick_irq, wrap_irq, interval_irq;
    logic [2:0]  evs;
    logic [7:0]  rd;
    logic [7:0]  lo;
    logic        err;
    int          err_count = 0;
    int          compares = 0;
    int          n;
    assign evs = {interval_irq, wrap_irq, tick_irq};
    always #4 pclk = ~pclk;
    tmr_block #(.TB_MHZ(4), .TICK_US(1)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_time(capture_time),
        .tick_irq(tick_irq), .wrap_irq(wrap_irq),
        .interval_irq(interval_irq));
    task automatic apb(input logic w, input logic [7:0] a, d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) err_count++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t data %h not %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic wait_ev(input int s, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (evs[s] !== 1'b1 && c < 1000);
    endtask
    task automatic finish_test;
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #50us;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'hA4, 8'h00);
        chk(rd, 8'h00);
        apb(1'b1, 8'hA0, 8'h05);
        apb(1'b1, 8'hA4, 8'hF3);
        apb(1'b0, 8'hA4, 8'h00);
        chk(rd, 8'h03);
        apb(1'b1, 8'hA4, 8'hF0);
        apb(1'b0, 8'hA0, 8'h00);
        chk(rd, 8'h05);
        wait_ev(2, n);
        wait_ev(2, n);
        // Six timebase steps of 31 or 32 cycles for reload 5
        chkf(n >= 185 && n <= 190, 1'b1);
        apb(1'b0, 8'h98, 8'h00);
        apb(1'b0, 8'h9C, 8'h00);
        chk(rd, 8'h00);
        apb(1'b1, 8'h98, 8'hFF);
        chkf(err, 1'b0);
        apb(1'b1, 8'h80, 8'hFF);
        apb(1'b1, 8'h84, 8'h01);
        #1;
        chk(capture_time[15:8], 8'h01);
        chk(capture_time[7:0], 8'hFF);
        apb(1'b0, 8'h80, 8'h00);
        lo = rd;
        // Upper byte must be the held one, not the live one
        repeat (40) @(posedge pclk);
        apb(1'b0, 8'h84, 8'h00);
        chkf(({rd, lo} - 16'h01FF) <= 16'h0001, 1'b1);
        chkf(prdata[31:8] == 24'h000000, 1'b1);
        apb(1'b1, 8'h80, 8'h00);
        #1;
        chk(capture_time[15:8], 8'h02);
        apb(1'b1, 8'h80, 8'hFE);
        apb(1'b1, 8'h84, 8'hFF);
        wait_ev(1, n);
        chkf(n < 100, 1'b1);
        wait_ev(0, n);
        wait_ev(0, n);
        chkf(n >= 124 && n <= 128, 1'b1);
        apb(1'b0, 8'h40, 8'h00);
        chkf(err, 1'b1);
        finish_test();
    end
endmodule // tmr_block_test
`default_nettype wire
